/* File: design/bank_selector.sv */
`timescale 1ns/1ps
// What this block does
// - After reset bank 1 is active until software or a request input moves it.
// - Writing 1 to 4 into the software bank register requests that bank.
// - Protection elements get settings only from the active bank.
// - The indicator shows the active bank always and follows each change.
// - With several request inputs high, the highest-numbered one wins.
// - Releasing the top request falls back to the next one, or to bank 1.
// - Every change of active bank writes an entry into the event log, except when the log is full (16 entries) and not read in that cycle: then it is dropped.
// - Breaker open or closed is derived from the breaker-state input.
// - With the breaker inhibit on, changes wait while the breaker is open.
// - With the overcurrent inhibit on, changes wait on enabled OC pickups.
// - With the high-voltage inhibit on, changes wait on enabled OV pickups.
// - With the low-voltage inhibit on, changes wait on enabled UV pickups.
// - With the low-frequency inhibit on, changes wait on enabled UF pickups.
// - Pickups of disabled elements never hold off a change.
module bank_selector #(
  parameter int ELEMS = 4
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Pins: bank requests for banks 2..4, breaker state
  input  wire logic [2:0]       grp_req_pin,
  input  wire logic             brk_state_pin,
  // Element pickups
  input  wire logic [ELEMS-1:0] oc_pickup,
  input  wire logic [ELEMS-1:0] ov_pickup,
  input  wire logic [ELEMS-1:0] uv_pickup,
  input  wire logic [ELEMS-1:0] uf_pickup,
  // Bank outputs and interrupt
  output logic      [1:0]       active_bank,
  output logic      [31:0]      bank_setting,
  output logic      [3:0]       bank_led,
  output logic                  irq
);
  initial begin
    if (ELEMS < 1 || ELEMS > 8)
      $error("ELEMS must be 1 to 8 to fit the enable register");
  end

  // Highest asserted request, 0 when none
  function automatic logic [1:0] req_bank(input logic [2:0] req);
    if (req[2]) return 2'h3;
    else if (req[1]) return 2'h2;
    else if (req[0]) return 2'h1;
    else return 2'h0;
  endfunction

  // Byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  // Synchronisers for the pins
  logic [2:0] req_s1_r, req_s2_r;
  logic       brk_s1_r, brk_s2_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      req_s1_r <= 3'h0;
      req_s2_r <= 3'h0;
      brk_s1_r <= 1'b0;
      brk_s2_r <= 1'b0;
    end else begin
      req_s1_r <= grp_req_pin;
      req_s2_r <= req_s1_r;
      brk_s1_r <= brk_state_pin;
      brk_s2_r <= brk_s1_r;
    end
  end

  logic [31:0]       ctrl_r, ctrl_nxt;
  logic [31:0]       elem_r, elem_nxt;
  logic [31:0]       set_r [bank_sel_pkg::N_BANK];
  logic [31:0]       set_nxt [bank_sel_pkg::N_BANK];
  logic [1:0]        act_r, act_nxt, des_r, des_nxt, rprev_r, rprev_nxt;
  logic              src_r, src_nxt;
  bank_sel_pkg::hold_st_t st_r, st_nxt;
  logic [bank_sel_pkg::N_EV-1:0] ist_r, ist_nxt, ien_r, ien_nxt, ev;
  logic [bank_sel_pkg::TS_W-1:0] ts_r;
  logic              ack_r, ack_nxt;
  logic [3:0]        led_r, led_nxt;
  logic [31:0]       dat_r, dat_nxt, bset_r;
  logic              closed, hold_c, go, hit, acc, wr, pop;
  logic [1:0]        rq, edit_idx;
  logic [2:0]        edit, swv;
  logic [31:0]       log_word, log_rd, status;
  logic              log_ovf;
  logic [$clog2(bank_sel_pkg::LOG_DEPTH+1)-1:0] log_cnt;
  logic [ELEMS-1:0]  oc_m, ov_m, uv_m, uf_m;

  // Hold-off terms; disabled elements are masked out first
  always_comb begin
    closed = brk_s2_r == ctrl_r[bank_sel_pkg::CTRL_BRK_POL];
    oc_m = oc_pickup & elem_r[0*ELEMS +: ELEMS];
    ov_m = ov_pickup & elem_r[1*ELEMS +: ELEMS];
    uv_m = uv_pickup & elem_r[2*ELEMS +: ELEMS];
    uf_m = uf_pickup & elem_r[3*ELEMS +: ELEMS];
    hold_c = (ctrl_r[bank_sel_pkg::CTRL_BRK_EN] && !closed)
          || (ctrl_r[bank_sel_pkg::CTRL_OC_EN] && |oc_m)
          || (ctrl_r[bank_sel_pkg::CTRL_HV_EN] && |ov_m)
          || (ctrl_r[bank_sel_pkg::CTRL_LV_EN] && |uv_m)
          || (ctrl_r[bank_sel_pkg::CTRL_LF_EN] && |uf_m);
    go = des_r != act_r && !hold_c;
  end

  // Bus decode; a write lands on the edge that ends the cycle
  always_comb begin
    hit  = wb_cyc_i && wb_stb_i;
    acc  = hit && ack_r;
    wr   = acc && wb_we_i;
    pop  = acc && !wb_we_i && wb_adr_i == bank_sel_pkg::LOG_DATA_OFF;
    edit = ctrl_r[bank_sel_pkg::CTRL_EDIT_LSB +: bank_sel_pkg::EDIT_W];
    edit_idx = (edit == 3'h0 || edit > bank_sel_pkg::SW_BANK_MAX)
             ? act_r : 2'(edit - 3'h1);
    swv  = wb_dat_i[2:0];
    rq   = req_bank(req_s2_r);
    status = 32'h0;
    status[bank_sel_pkg::ST_ACT_LSB +: 2] = act_r;
    status[bank_sel_pkg::ST_DES_LSB +: 2] = des_r;
    status[bank_sel_pkg::ST_PEND]   = st_r == bank_sel_pkg::ST_PENDING;
    status[bank_sel_pkg::ST_CLOSED] = closed;
    status[bank_sel_pkg::ST_HELD]   = hold_c;
    status[bank_sel_pkg::ST_REQ_LSB +: 3] = req_s2_r;
  end

  // Register, selection and interrupt next state
  always_comb begin
    ctrl_nxt  = ctrl_r;
    elem_nxt  = elem_r;
    set_nxt   = set_r;
    ien_nxt   = ien_r;
    des_nxt   = des_r;
    src_nxt   = src_r;
    act_nxt   = act_r;
    st_nxt    = st_r;
    rprev_nxt = rq;
    ack_nxt   = hit && !ack_r;
    dat_nxt   = dat_r;
    ev        = '0;
    // a new top request, or none, retargets the bank
    if (rq != rprev_r) begin
      des_nxt = rq;
      src_nxt = 1'b1;
    end
    if (wr) begin
      if (wb_adr_i == bank_sel_pkg::CTRL_OFF) begin
        ctrl_nxt = merge(ctrl_r, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == bank_sel_pkg::ELEM_EN_OFF) begin
        elem_nxt = merge(elem_r, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == bank_sel_pkg::INT_EN_OFF) begin
        ien_nxt = wb_sel_i[0] ? wb_dat_i[bank_sel_pkg::N_EV-1:0] : ien_r;
      end else if (wb_adr_i == bank_sel_pkg::SET_DATA_OFF) begin
        set_nxt[edit_idx] = merge(set_r[edit_idx], wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == bank_sel_pkg::SW_BANK_OFF) begin
        // software request, taken over a same-cycle input change
        if (wb_sel_i[0] && swv >= bank_sel_pkg::SW_BANK_MIN
            && swv <= bank_sel_pkg::SW_BANK_MAX) begin
          des_nxt = 2'(swv - 3'h1);
          src_nxt = 1'b0;
        end
      end
    end
    // apply only with no hold; otherwise stay pending
    case (st_r)
      bank_sel_pkg::ST_STEADY: begin
        if (go) begin
          act_nxt = des_r;
          ev[bank_sel_pkg::EV_CHANGE] = 1'b1;
        end else if (des_r != act_r) begin
          st_nxt = bank_sel_pkg::ST_PENDING;
          ev[bank_sel_pkg::EV_HELD] = 1'b1;
        end
      end
      bank_sel_pkg::ST_PENDING: begin
        if (go) begin
          act_nxt = des_r;
          ev[bank_sel_pkg::EV_CHANGE] = 1'b1;
          st_nxt = bank_sel_pkg::ST_STEADY;
        end else if (des_r == act_r) begin
          st_nxt = bank_sel_pkg::ST_STEADY;
        end
      end
      default: st_nxt = bank_sel_pkg::ST_STEADY;
    endcase
    // Indicator is built from the next bank so it lands with active_bank
    led_nxt = 4'h1 << act_nxt;
    ev[bank_sel_pkg::EV_OVF] = log_ovf;
    // Set wins over a clear in the same cycle
    ist_nxt = ist_r | ev;
    if (wr && wb_adr_i == bank_sel_pkg::INT_CLR_OFF && wb_sel_i[0]) begin
      ist_nxt = (ist_r & ~wb_dat_i[bank_sel_pkg::N_EV-1:0]) | ev;
    end
    // Read data is captured with the ack; unmapped reads give zero
    if (hit && !ack_r) begin
      if (wb_adr_i == bank_sel_pkg::CTRL_OFF) dat_nxt = ctrl_r;
      else if (wb_adr_i == bank_sel_pkg::ELEM_EN_OFF) dat_nxt = elem_r;
      else if (wb_adr_i == bank_sel_pkg::STATUS_OFF) dat_nxt = status;
      else if (wb_adr_i == bank_sel_pkg::INT_STAT_OFF)
        dat_nxt = 32'(ist_r);
      else if (wb_adr_i == bank_sel_pkg::INT_EN_OFF)
        dat_nxt = 32'(ien_r);
      else if (wb_adr_i == bank_sel_pkg::LOG_CNT_OFF)
        dat_nxt = 32'(log_cnt);
      else if (wb_adr_i == bank_sel_pkg::LOG_DATA_OFF)
        dat_nxt = log_cnt != '0 ? log_rd : 32'h0;
      else if (wb_adr_i == bank_sel_pkg::SET_DATA_OFF)
        dat_nxt = set_r[edit_idx];
      else if (wb_adr_i == bank_sel_pkg::SW_BANK_OFF)
        dat_nxt = 32'({1'b0, act_r} + 3'h1);
      else dat_nxt = 32'h0;
    end
  end

  // Registers only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r  <= bank_sel_pkg::CTRL_RST;
      elem_r  <= bank_sel_pkg::ELEM_EN_RST;
      for (int i = 0; i < bank_sel_pkg::N_BANK; i++) set_r[i] <= 32'h0;
      ien_r   <= '0;
      ist_r   <= '0;
      act_r   <= bank_sel_pkg::BANK_RST;
      des_r   <= bank_sel_pkg::BANK_RST;
      rprev_r <= 2'h0;
      src_r   <= 1'b0;
      st_r    <= bank_sel_pkg::ST_STEADY;
      ack_r   <= 1'b0;
      dat_r   <= 32'h0;
      ts_r    <= '0;
      bset_r  <= 32'h0;
      led_r   <= 4'h1;
    end else begin
      ctrl_r  <= ctrl_nxt;
      elem_r  <= elem_nxt;
      set_r   <= set_nxt;
      ien_r   <= ien_nxt;
      ist_r   <= ist_nxt;
      act_r   <= act_nxt;
      des_r   <= des_nxt;
      rprev_r <= rprev_nxt;
      src_r   <= src_nxt;
      st_r    <= st_nxt;
      ack_r   <= ack_nxt;
      dat_r   <= dat_nxt;
      ts_r    <= ts_r + 1'b1;
      bset_r  <= set_r[act_r];
      led_r   <= led_nxt;
    end
  end

  // log entry for each change: time, source, old and new bank
  always_comb begin
    log_word = 32'h0;
    log_word[bank_sel_pkg::LOG_NEW_LSB +: 2] = des_r;
    log_word[bank_sel_pkg::LOG_OLD_LSB +: 2] = act_r;
    log_word[bank_sel_pkg::LOG_SRC] = src_r;
    log_word[bank_sel_pkg::LOG_TS_LSB +: bank_sel_pkg::TS_W] = ts_r;
  end

  event_log #(
    .DEPTH (bank_sel_pkg::LOG_DEPTH),
    .W     (32)
  ) u_log (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .push      (ev[bank_sel_pkg::EV_CHANGE]),
    .push_data (log_word),
    .overflow  (log_ovf),
    .pop       (pop),
    .rd_data   (log_rd),
    .count     (log_cnt)
  );

  assign active_bank  = act_r;
  assign bank_setting = bset_r;
  assign bank_led     = led_r;
  assign irq          = |(ist_r & ien_r);
  assign wb_ack_o     = ack_r;
  assign wb_dat_o     = dat_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_reset_bank_one: assert property (
    @(posedge sys_clk) disable iff (1'b0) rst |=> active_bank == 2'h0)
    else $error("bank not 1 after reset");
  a_sw_write_target: assert property (
    (wr && wb_adr_i == bank_sel_pkg::SW_BANK_OFF && wb_sel_i[0]
     && swv >= 3'h1 && swv <= 3'h4) |=> des_r == $past(swv[1:0]) - 2'h1)
    else $error("software bank not taken");
  a_led_follows: assert property (
    $changed(active_bank) |-> bank_led == (4'h1 << active_bank))
    else $error("indicator wrong after change");
  a_top_req_wins: assert property (
    (req_s2_r[2] && !$past(req_s2_r[2]) && !wr) |=> des_r == 2'h3)
    else $error("highest request did not win");
  a_release_fall: assert property (
    (req_s2_r == 3'h0 && $past(req_s2_r) != 3'h0 && !wr) |=> des_r == 2'h0)
    else $error("release did not fall back");
  a_change_logged: assert property (
    $changed(act_r) |-> ($past(log_cnt) != log_cnt || $past(pop)
                         || $past(log_cnt) == 5'(bank_sel_pkg::LOG_DEPTH)))
    else $error("bank change not logged");
  a_brk_holds: assert property (
    (ctrl_r[bank_sel_pkg::CTRL_BRK_EN] && !closed && des_r != act_r)
    |=> $stable(act_r))
    else $error("change during open breaker");
  a_oc_holds: assert property (
    (ctrl_r[bank_sel_pkg::CTRL_OC_EN] && |oc_m) |=> $stable(act_r))
    else $error("change during OC pickup");
  a_hv_holds: assert property (
    (ctrl_r[bank_sel_pkg::CTRL_HV_EN] && |ov_m) |=> $stable(act_r))
    else $error("change during OV pickup");
  a_lv_holds: assert property (
    (ctrl_r[bank_sel_pkg::CTRL_LV_EN] && |uv_m) |=> $stable(act_r))
    else $error("change during UV pickup");
  a_lf_holds: assert property (
    (ctrl_r[bank_sel_pkg::CTRL_LF_EN] && |uf_m) |=> $stable(act_r))
    else $error("change during UF pickup");
  a_masked_free: assert property (
    (des_r != act_r && !(ctrl_r[bank_sel_pkg::CTRL_BRK_EN] && !closed)
     && (oc_m | ov_m | uv_m | uf_m) == '0) |=> act_r == $past(des_r))
    else $error("disabled pickup held a change");
  a_clear_applies: assert property (
    (des_r != act_r && !hold_c) |=> act_r == $past(des_r))
    else $error("pending change not applied");

  c_sw_change: cover property (wr && wb_adr_i == bank_sel_pkg::SW_BANK_OFF);
  c_held_then_go: cover property (st_r == bank_sel_pkg::ST_PENDING ##1 go);
  c_top_req: cover property (act_r == 2'h3 && req_s2_r == 3'h7);
  c_irq: cover property (irq);
endmodule

/* File: design/event_log.sv */
`timescale 1ns/1ps
module event_log #(
  parameter int DEPTH = bank_sel_pkg::LOG_DEPTH,
  parameter int W     = 32
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  // Write side
  input  wire logic                   push,
  input  wire logic [W-1:0]           push_data,
  output logic                        overflow,
  // Read side
  input  wire logic                   pop,
  output logic [W-1:0]                rd_data,
  output logic [$clog2(DEPTH+1)-1:0]  count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("event_log depth must be a power of two, at least 2");
  end

  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic          ovf_r, ovf_nxt;
  logic          do_push, do_pop;

  // Full log drops the newest entry, unless a pop frees a slot in the same cycle, so older history is kept
  always_comb begin
    do_pop  = pop && cnt_r != '0;
    do_push = push && (cnt_r != CW'(DEPTH) || do_pop);
    wp_nxt  = do_push ? wp_r + AW'(1) : wp_r;
    rp_nxt  = do_pop ? rp_r + AW'(1) : rp_r;
    cnt_nxt = cnt_r + CW'(do_push) - CW'(do_pop);
    ovf_nxt = push && !do_push;
  end

  // Pointer state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      ovf_r <= 1'b0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  // Storage needs no reset
  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem_r[wp_r] <= push_data;
    end
  end

  assign rd_data  = mem_r[rp_r];
  assign count    = cnt_r;
  assign overflow = ovf_r;
endmodule

/* File: pkg/bank_sel_pkg.sv */
package bank_sel_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF     = 8'h00;
  localparam logic [7:0] ELEM_EN_OFF  = 8'h04;
  localparam logic [7:0] STATUS_OFF   = 8'h08;
  localparam logic [7:0] INT_STAT_OFF = 8'h0c;
  localparam logic [7:0] INT_CLR_OFF  = 8'h10;
  localparam logic [7:0] INT_EN_OFF   = 8'h14;
  localparam logic [7:0] LOG_CNT_OFF  = 8'h18;
  localparam logic [7:0] LOG_DATA_OFF = 8'h1c;
  localparam logic [7:0] SET_DATA_OFF = 8'h20;
  localparam logic [7:0] SW_BANK_OFF  = 8'h24;
  // Control fields
  localparam int CTRL_BRK_EN = 0;
  localparam int CTRL_OC_EN  = 1;
  localparam int CTRL_HV_EN  = 2;
  localparam int CTRL_LV_EN  = 3;
  localparam int CTRL_LF_EN  = 4;
  localparam int CTRL_BRK_POL = 5;
  localparam int CTRL_EDIT_LSB = 8;
  localparam int EDIT_W = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0020;
  localparam logic [31:0] ELEM_EN_RST = 32'h0000_0000;
  // Status fields
  localparam int ST_ACT_LSB = 0;
  localparam int ST_DES_LSB = 2;
  localparam int ST_PEND   = 4;
  localparam int ST_CLOSED = 5;
  localparam int ST_HELD   = 6;
  localparam int ST_REQ_LSB = 8;
  // Event bits
  localparam int EV_CHANGE = 0;
  localparam int EV_HELD   = 1;
  localparam int EV_OVF    = 2;
  localparam int N_EV      = 3;
  // Banks: code 0..3 is bank 1..4
  localparam int N_BANK = 4;
  localparam logic [1:0] BANK_RST = 2'h0;
  localparam logic [2:0] SW_BANK_MIN = 3'h1;
  localparam logic [2:0] SW_BANK_MAX = 3'h4;
  // Log entry fields
  localparam int LOG_NEW_LSB = 0;
  localparam int LOG_OLD_LSB = 2;
  localparam int LOG_SRC     = 4;
  localparam int LOG_TS_LSB  = 16;
  localparam int TS_W        = 16;
  localparam int LOG_DEPTH   = 16;
  localparam int SYNC_STAGES = 2;
  typedef enum logic {ST_STEADY, ST_PENDING} hold_st_t;
endpackage

/* File: test/field_model.sv */
`timescale 1ns/1ps
// Far side of the selector: request inputs, breaker contact and pickups.
// Levels are relaunched on the clock so the bench can script them exactly.
module field_model (
  // Clock
  input  wire logic        sys_clk,
  // Bench commands; pickups packed as OC, OV, UV, UF nibbles
  input  wire logic [2:0]  req_cmd,
  input  wire logic        brk_cmd,
  input  wire logic [15:0] pu_cmd,
  // Levels toward the selector
  output logic      [2:0]  grp_req_pin,
  output logic             brk_state_pin,
  output logic      [3:0]  oc_pickup,
  output logic      [3:0]  ov_pickup,
  output logic      [3:0]  uv_pickup,
  output logic      [3:0]  uf_pickup
);
  // Contacts are plain levels; syncing them is the selector's job
  always_ff @(posedge sys_clk) begin
    grp_req_pin   <= req_cmd;
    brk_state_pin <= brk_cmd;
    oc_pickup     <= pu_cmd[3:0];
    ov_pickup     <= pu_cmd[7:4];
    uv_pickup     <= pu_cmd[11:8];
    uf_pickup     <= pu_cmd[15:12];
  end
endmodule

/* File: test/tb_bank_selector.sv */
`timescale 1ns/1ps
module tb_bank_selector;
  // Bench state
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic [2:0]  req_cmd = 3'h0;
  logic        brk_cmd = 1'b1;
  logic [15:0] pu_cmd = 16'h0;
  logic [2:0]  grp_req_pin;
  logic        brk_state_pin;
  logic [3:0]  oc_pickup;
  logic [3:0]  ov_pickup;
  logic [3:0]  uv_pickup;
  logic [3:0]  uf_pickup;
  logic [1:0]  active_bank;
  logic [31:0] bank_setting;
  logic [3:0]  bank_led;
  logic        irq;
  logic [31:0] words [4];
  logic [2:0]  hand [6] = '{3'h1, 3'h3, 3'h7, 3'h3, 3'h1, 3'h0};
  logic [31:0] rnd = 32'hfaaa;
  int          bad_count = 0;
  int          check_count = 0;

  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  field_model field (
    .sys_clk(sys_clk), .req_cmd(req_cmd), .brk_cmd(brk_cmd),
    .pu_cmd(pu_cmd), .grp_req_pin(grp_req_pin),
    .brk_state_pin(brk_state_pin), .oc_pickup(oc_pickup),
    .ov_pickup(ov_pickup), .uv_pickup(uv_pickup), .uf_pickup(uf_pickup)
  );

  bank_selector #(.ELEMS(4)) dut (
    .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .grp_req_pin(grp_req_pin),
    .brk_state_pin(brk_state_pin), .oc_pickup(oc_pickup),
    .ov_pickup(ov_pickup), .uv_pickup(uv_pickup), .uf_pickup(uf_pickup),
    .active_bank(active_bank), .bank_setting(bank_setting),
    .bank_led(bank_led), .irq(irq)
  );

  // Next pseudo-random word; fixed start keeps runs repeatable
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Bank code expected from the pins: highest request, else bank 1
  function automatic logic [1:0] top_code(input logic [2:0] r);
    return r[2] ? 2'h3 : r[1] ? 2'h2 : r[0] ? 2'h1 : 2'h0;
  endfunction

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask

  // One classic cycle, held until the edge that samples ack high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    wdat <= d;
    do @(posedge sys_clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  // Bounded wait for a bank, then indicator and setting word
  task automatic see_bank(input logic [1:0] c, input string what);
    for (int i = 0; i < 12 && active_bank !== c; i++) @(posedge sys_clk);
    @(posedge sys_clk);
    chk({30'h0, active_bank}, {30'h0, c}, what);
    chk({28'h0, bank_led}, {28'h0, 4'h1 << c}, what);
    chk(bank_setting, words[c], what);
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  // Verdict in one place
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Whole run is several hundred cycles; a stuck handshake ends here
  initial begin
    repeat (40000) @(posedge sys_clk);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    logic [31:0] q;
    logic [2:0]  r;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    chk({30'h0, active_bank}, 32'h0, "reset bank");
    chk({28'h0, bank_led}, 32'h1, "reset led");
    chk(bank_setting, 32'h0, "reset word");
    wb(1'b0, bank_sel_pkg::CTRL_OFF, 32'h0, q);
    chk(q, bank_sel_pkg::CTRL_RST, "ctrl reset");
    wb(1'b0, bank_sel_pkg::SW_BANK_OFF, 32'h0, q);
    chk(q, 32'h1, "sw bank reset");
    wb(1'b0, 8'h30, 32'h0, q);
    chk(q, 32'h0, "unmapped read");
    end_test("reset");
    // Distinct setting word per bank, then edit back on the active bank
    for (int b = 1; b <= 4; b++) begin
      rnd = lfsr(rnd);
      words[b-1] = rnd;
      wr(bank_sel_pkg::CTRL_OFF, bank_sel_pkg::CTRL_RST |
         (32'(b) << bank_sel_pkg::CTRL_EDIT_LSB));
      wr(bank_sel_pkg::SET_DATA_OFF, rnd);
    end
    wr(bank_sel_pkg::CTRL_OFF, bank_sel_pkg::CTRL_RST);
    // Edit selection 0 reaches the active bank, bank 1 here
    wb(1'b0, bank_sel_pkg::SET_DATA_OFF, 32'h0, q);
    chk(q, words[0], "edit active bank");
    // Software walks 2, 3, 4, 1
    for (int i = 1; i <= 4; i++) begin
      wr(bank_sel_pkg::SW_BANK_OFF, 32'((i % 4) + 1));
      see_bank(2'(i % 4), "software bank");
    end
    // Out of range values are ignored
    wr(bank_sel_pkg::SW_BANK_OFF, 32'h0);
    wr(bank_sel_pkg::SW_BANK_OFF, 32'h5);
    see_bank(2'h0, "sw out of range");
    // One log entry per change: new code, old code, software source
    wb(1'b0, bank_sel_pkg::LOG_CNT_OFF, 32'h0, q);
    chk(q, 32'h4, "log count");
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, bank_sel_pkg::LOG_DATA_OFF, 32'h0, q);
      chk(q & 32'h1f, 32'((i << 2) | ((i + 1) % 4)), "log entry");
    end
    end_test("software");
    // Interrupt: raise, clear, mask, unmask
    wr(bank_sel_pkg::INT_CLR_OFF, 32'h7);
    wr(bank_sel_pkg::INT_EN_OFF, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wr(bank_sel_pkg::SW_BANK_OFF, 32'h3);
    see_bank(2'h2, "sw bank 3");
    chk({31'h0, irq}, 32'h1, "irq on change");
    wr(bank_sel_pkg::INT_CLR_OFF, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0, "irq clear");
    wr(bank_sel_pkg::INT_EN_OFF, 32'h0);
    wr(bank_sel_pkg::SW_BANK_OFF, 32'h1);
    see_bank(2'h0, "sw bank 1");
    chk({31'h0, irq}, 32'h0, "irq masked");
    wb(1'b0, bank_sel_pkg::INT_STAT_OFF, 32'h0, q);
    chk(q & 32'h1, 32'h1, "sticky change");
    wr(bank_sel_pkg::INT_EN_OFF, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    wr(bank_sel_pkg::INT_EN_OFF, 32'h0);
    end_test("interrupt");
    // Requests: scripted climb and fall, then random with stray pickups
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr(rnd);
      r = (i < 6) ? hand[i] : rnd[2:0];
      req_cmd <= r;
      pu_cmd <= rnd[31:16];
      see_bank(top_code(r), "request priority");
    end
    req_cmd <= 3'h0;
    pu_cmd <= 16'h0;
    see_bank(2'h0, "no request");
    end_test("priority");
    // Each inhibit holds a change until its condition clears
    wr(bank_sel_pkg::ELEM_EN_OFF, 32'hffff);
    for (int k = 0; k < 5; k++) begin
      rnd = lfsr(rnd);
      wr(bank_sel_pkg::CTRL_OFF, bank_sel_pkg::CTRL_RST |
         (32'h1 << (bank_sel_pkg::CTRL_BRK_EN + k)));
      req_cmd <= 3'h1;
      see_bank(2'h1, "bank 2 in");
      if (k == 0) brk_cmd <= 1'b0;
      else pu_cmd <= 16'h1 << (4 * (k - 1) + int'(rnd[1:0]));
      repeat (4) @(posedge sys_clk);
      req_cmd <= 3'h0;
      repeat (12) @(posedge sys_clk);
      chk({30'h0, active_bank}, 32'h1, "held");
      wb(1'b0, bank_sel_pkg::STATUS_OFF, 32'h0, q);
      chk({31'h0, q[bank_sel_pkg::ST_PEND]}, 32'h1, "pending");
      chk({31'h0, q[bank_sel_pkg::ST_CLOSED]}, 32'(k != 0), "closed");
      brk_cmd <= 1'b1;
      pu_cmd <= 16'h0;
      see_bank(2'h0, "released");
    end
    end_test("inhibits");
    // Two conditions: clearing one is not enough
    wr(bank_sel_pkg::CTRL_OFF, bank_sel_pkg::CTRL_RST | 32'h3);
    req_cmd <= 3'h1;
    see_bank(2'h1, "bank 2 in");
    brk_cmd <= 1'b0;
    pu_cmd <= 16'h4;
    repeat (4) @(posedge sys_clk);
    req_cmd <= 3'h0;
    repeat (8) @(posedge sys_clk);
    brk_cmd <= 1'b1;
    repeat (12) @(posedge sys_clk);
    chk({30'h0, active_bank}, 32'h1, "still held");
    pu_cmd <= 16'h0;
    see_bank(2'h0, "all clear");
    // Disabled elements never hold
    wr(bank_sel_pkg::CTRL_OFF, bank_sel_pkg::CTRL_RST | 32'h2);
    wr(bank_sel_pkg::ELEM_EN_OFF, 32'hfff0);
    pu_cmd <= 16'h000f;
    req_cmd <= 3'h1;
    see_bank(2'h1, "disabled up");
    req_cmd <= 3'h0;
    see_bank(2'h0, "disabled down");
    // Over 16 changes since the last pop: log full, overflow and held seen
    wb(1'b0, bank_sel_pkg::LOG_CNT_OFF, 32'h0, q);
    chk(q, 32'h10, "log full");
    wb(1'b0, bank_sel_pkg::INT_STAT_OFF, 32'h0, q);
    chk(q, 32'h7, "all events");
    end_test("combined");
    // Reset in mid-run drops a software bank back to bank 1
    wr(bank_sel_pkg::SW_BANK_OFF, 32'h4);
    see_bank(2'h3, "bank 4 before reset");
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk({30'h0, active_bank}, 32'h0, "bank after reset");
    chk({28'h0, bank_led}, 32'h1, "led after reset");
    wb(1'b0, bank_sel_pkg::LOG_CNT_OFF, 32'h0, q);
    chk(q, 32'h0, "log after reset");
    end_test("reset again");
    conclude();
  end
endmodule
